/* rtl/vecsel_params.svh */
// Constants for the interrupt vector selection block.
`ifndef VECSEL_PARAMS_SVH
`define VECSEL_PARAMS_SVH

// ----------------------------------------------------------------------
// Vector tables
// ----------------------------------------------------------------------
`define PRI_TABLE_BASE 24'h000004
`define ALT_TABLE_BASE 24'h000104
`define RESET_PC 24'h000000
`define EXT0_PRI_ADDR 24'h000014
`define EXT0_ALT_ADDR 24'h000114
`define NUM_TRAP 8
`define NUM_IRQ 118
`define NUM_VEC 126
`define EXT0_SLOT 7'h08

// ----------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_MASK 8'h08
`define OFS_VECTOR 8'h0c
`define OFS_TBL_INDEX 8'h10
`define OFS_TBL_DATA 8'h14
`define ALT_SEL_BIT 15
`define EVT_ISSUE_BIT 0
`define EVT_TRAP_BIT 1
`define EVT_WIDTH 2

`endif

/* rtl/vecsel_pkg.sv */
// Types shared by the interrupt vector selection block.
package vecsel_pkg;

	// Vector handed to the CPU core.
	typedef struct packed {
		logic alt;
		logic trap;
		logic [6:0] slot;
		logic [23:0] fetch_addr;
		logic [23:0] isr_addr;
	} vec_type;

endpackage

/* rtl/vector_select.sv */
// Interrupt vector selection with primary and alternate tables.
//
// The implementer's own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "vecsel_params.svh"

// Contract
// - The alternate table follows the primary one, entry for entry.
// - Control bit 15 set steers every vector fetch to the alternate table.
// - Each alternate entry lies a fixed distance above its primary entry.
// - Reset does not pass through the vector logic and fetches no vector.
// - Reset clears all registers and forces the program counter to zero; the table memory read through the data register is left unreset.
// - After reset execution starts at address 000000h.
// - Eight trap vectors 0 to 7 sit at consecutive two-word addresses.
// - Each source has one vector, external interrupt 0 at 000014h/000114h.
// - Each table entry holds a 24-bit service routine start address.
// - Among equal pending sources the lowest table address wins.

module vector_select (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [7:0] trap_req,
	input wire logic [117:0] irq_req,
	input wire logic vec_take,
	output logic vec_valid,
	output vecsel_pkg::vec_type vec_out,
	output logic [23:0] start_pc,
	output logic irq_o
);

	// ------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------
	function automatic logic [31:0] lane_merge(input logic [31:0] old,
		input logic [31:0] val, input logic [3:0] sel);
		logic [31:0] m;
		m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		return (old & ~m) | (val & m);
	endfunction

	// Scans downward so the lowest pending slot is the one left standing.
	function automatic logic [6:0] lowest_set(input logic [125:0] v);
		logic [6:0] r;
		r = 7'h00;
		for (int i = `NUM_VEC - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = 7'(i);
			end
		end
		return r;
	endfunction

	function automatic logic [23:0] fetch_of(input logic alt,
		input logic [6:0] slot);
		return (alt ? `ALT_TABLE_BASE : `PRI_TABLE_BASE) +
			{16'h0000, slot, 1'h0};
	endfunction

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	logic [23:0] table_mem [0:255];
	logic [31:0] ctrl_q, ctrl_d;
	logic [1:0] status_q, status_d;
	logic [1:0] mask_q, mask_d;
	logic [7:0] tbl_index_q, tbl_index_d;
	logic ack_q;
	logic [31:0] rdat_q, rdat_d;
	logic valid_q, valid_d;
	vecsel_pkg::vec_type vec_q, vec_d;
	logic irq_q;
	logic [23:0] pc_q;

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	wire bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
	wire bus_wr = bus_req & wb_we_i;
	wire hit_ctrl = (wb_adr_i == `OFS_CTRL);
	wire hit_status = (wb_adr_i == `OFS_STATUS);
	wire hit_mask = (wb_adr_i == `OFS_MASK);
	wire hit_vector = (wb_adr_i == `OFS_VECTOR);
	wire hit_index = (wb_adr_i == `OFS_TBL_INDEX);
	wire hit_data = (wb_adr_i == `OFS_TBL_DATA);
	wire [31:0] wr_status = lane_merge(32'h0, wb_dat_i, wb_sel_i);
	wire [31:0] wr_table = lane_merge({8'h00, table_mem[tbl_index_q]},
		wb_dat_i, wb_sel_i);
	wire [31:0] wr_index = lane_merge({24'h0, tbl_index_q}, wb_dat_i,
		wb_sel_i);
	wire [31:0] wr_mask = lane_merge({30'h0, mask_q}, wb_dat_i, wb_sel_i);
	wire [31:0] vector_word = {22'h0, valid_q, vec_q.alt, vec_q.trap,
		vec_q.slot};

	// Unmapped addresses read as zero and ignore writes, but still ack.
	assign rdat_d = hit_ctrl ? ctrl_q :
		hit_status ? {30'h0, status_q} :
		hit_mask ? {30'h0, mask_q} :
		hit_vector ? vector_word :
		hit_index ? {24'h0, tbl_index_q} :
		hit_data ? {8'h00, table_mem[tbl_index_q]} : 32'h0;

	// Only the select bit of the control word is implemented.
	assign ctrl_d = (bus_wr & hit_ctrl) ?
		(lane_merge(ctrl_q, wb_dat_i, wb_sel_i) &
		(32'h1 << `ALT_SEL_BIT)) : ctrl_q;
	assign mask_d = (bus_wr & hit_mask) ? wr_mask[1:0] : mask_q;
	assign tbl_index_d = (bus_wr & hit_index) ? wr_index[7:0] :
		tbl_index_q;

	// ------------------------------------------------------------------
	// Arbitration
	// ------------------------------------------------------------------
	wire alt_sel = ctrl_q[`ALT_SEL_BIT];
	wire [125:0] pending = {irq_req, trap_req};
	wire any_pending = |pending;
	wire [6:0] win_slot = lowest_set(pending);
	wire [7:0] win_index = {alt_sel, win_slot};
	wire [23:0] win_isr = table_mem[win_index];
	wire issue = ~valid_q & any_pending;

	always_comb begin
		vec_d = vec_q;
		if (issue) begin
			vec_d.alt = alt_sel;
			vec_d.trap = (win_slot < 7'(`NUM_TRAP));
			vec_d.slot = win_slot;
			vec_d.fetch_addr = fetch_of(alt_sel, win_slot);
			vec_d.isr_addr = win_isr;
		end
	end

	assign valid_d = issue | (valid_q & ~vec_take);

	// Set wins over a write-one clear arriving in the same cycle.
	wire [1:0] evt_set = {issue & (win_slot < 7'(`NUM_TRAP)), issue};
	wire [1:0] evt_clr = (bus_wr & hit_status) ? wr_status[1:0] : 2'h0;
	assign status_d = (status_q & ~evt_clr) | evt_set;
	wire irq_d = |(status_d & mask_d);

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	// Table memory is program store and is deliberately left unreset.
	always_ff @(posedge clk_sys) begin
		if (bus_wr & hit_data) begin
			table_mem[tbl_index_q] <= wr_table[23:0];
		end
	end

	// Reset goes straight to the flops and never raises a vector.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			ctrl_q <= 32'h0;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			status_q <= 2'h0;
		end else begin
			status_q <= status_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			mask_q <= 2'h0;
		end else begin
			mask_q <= mask_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			tbl_index_q <= 8'h00;
		end else begin
			tbl_index_q <= tbl_index_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			ack_q <= 1'h0;
		end else begin
			ack_q <= bus_req;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			rdat_q <= 32'h0;
		end else begin
			rdat_q <= rdat_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			valid_q <= 1'h0;
		end else begin
			valid_q <= valid_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			vec_q <= '0;
		end else begin
			vec_q <= vec_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			irq_q <= 1'h0;
		end else begin
			irq_q <= irq_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			pc_q <= `RESET_PC;
		end else begin
			pc_q <= pc_q;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
	assign vec_valid = valid_q;
	assign vec_out = vec_q;
	assign start_pc = pc_q;
	assign irq_o = irq_q;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	wire [125:0] below_win = (126'h1 << win_slot) - 126'h1;

	chk_fetch_formula: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		valid_q |-> vec_q.fetch_addr ==
		{15'h0, vec_q.alt, 7'(vec_q.slot + 7'h02), 1'h0})
		else $error("fetch address not base plus twice slot");
	chk_alt_follows_ctrl: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		$rose(valid_q) |-> vec_q.alt == $past(ctrl_q[`ALT_SEL_BIT]))
		else $error("table choice does not follow select bit");
	chk_alt_offset: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		valid_q |-> vec_q.fetch_addr[23:9] == 15'h0 &&
		vec_q.fetch_addr[8] == vec_q.alt)
		else $error("alternate entry not at fixed distance");
	chk_reset_clears: assert property (
		@(posedge clk_sys)
		!rst_b |=> !valid_q && !irq_q && ctrl_q == 32'h0)
		else $error("reset left a vector or control state");
	chk_start_pc: assert property (
		@(posedge clk_sys)
		$rose(rst_b) |-> (start_pc == `RESET_PC) [*3])
		else $error("start address not zero after reset");
	chk_pc_constant: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		start_pc == `RESET_PC)
		else $error("start address moved away from zero");
	chk_trap_class: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		valid_q |-> vec_q.trap == (vec_q.slot < 7'(`NUM_TRAP)))
		else $error("trap class wrong for slot");
	chk_ext0_addr: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		valid_q && vec_q.slot == `EXT0_SLOT |-> vec_q.fetch_addr ==
		(vec_q.alt ? `EXT0_ALT_ADDR : `EXT0_PRI_ADDR))
		else $error("external interrupt 0 at wrong address");
	chk_lowest_wins: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		issue |-> (pending & below_win) == 126'h0 ##1 vec_q.slot ==
		$past(win_slot))
		else $error("a lower pending slot was passed over");
	chk_isr_from_table: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		issue |=> vec_q.isr_addr == $past(win_isr))
		else $error("service address not from selected entry");
	chk_valid_needs_req: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		$rose(valid_q) |-> $past(any_pending))
		else $error("vector offered with nothing pending");
	chk_vec_stable: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		valid_q && !vec_take |=> valid_q && $stable(vec_q))
		else $error("offered vector changed before it was taken");
	chk_take_drops: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		valid_q && vec_take |=> !valid_q)
		else $error("taken vector still offered");

	// ------------------------------------------------------------------
	// Bus and status checks
	// ------------------------------------------------------------------
	chk_ack_single: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	chk_ack_follows_req: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered next cycle");
	chk_status_sticky: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		status_q[0] && !(bus_wr && hit_status) |=> status_q[0])
		else $error("status bit lost without a clear");
	chk_issue_sets: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		issue |=> status_q[0] && (status_q[1] || !vec_q.trap))
		else $error("issued vector did not set its status");
	chk_irq_level: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		irq_o == |(status_q & mask_q))
		else $error("interrupt output disagrees with status and mask");

	cov_alt_issue: cover property (@(posedge clk_sys) disable iff (!rst_b)
		$rose(valid_q) && vec_q.alt);
	cov_trap_issue: cover property (@(posedge clk_sys) disable iff (!rst_b)
		$rose(valid_q) && vec_q.trap);
	cov_two_pending: cover property (@(posedge clk_sys) disable iff (!rst_b)
		issue && $countones(pending) > 1);
	cov_irq_raised: cover property (@(posedge clk_sys) disable iff (!rst_b)
		$rose(irq_o));
	cov_slow_take: cover property (@(posedge clk_sys) disable iff (!rst_b)
		valid_q && vec_take && $past(valid_q, 8));

endmodule
`default_nettype wire

/* testbench/cpu_fetch_model.sv */
// CPU core model that takes the interrupt vectors offered to it.
`timescale 1ns/100ps
`default_nettype none
module cpu_fetch_model (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic vec_valid,
	input wire vecsel_pkg::vec_type vec_out,
	input wire logic [3:0] delay,
	output logic vec_take,
	output vecsel_pkg::vec_type got,
	output logic [7:0] n_got
);
	logic [3:0] wait_q;
	// A slow core lets the vector stand for delay extra cycles first.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			vec_take <= 1'h0;
			wait_q <= 4'h0;
			got <= '0;
			n_got <= 8'h00;
		end else begin
			vec_take <= 1'h0;
			if (vec_valid && !vec_take) begin
				if (wait_q >= delay) begin
					vec_take <= 1'h1;
					got <= vec_out;
					n_got <= n_got + 8'h01;
					wait_q <= 4'h0;
				end else begin
					wait_q <= wait_q + 4'h1;
				end
			end
		end
	end
endmodule
`default_nettype wire

/* testbench/interrupt_vector_selection_tb_top.sv */
// Self-checking bench for the interrupt vector selection block.
`timescale 1ns/100ps
`default_nettype none
`include "vecsel_params.svh"
module interrupt_vector_selection_tb_top;
	logic clk_sys = 1'h0;
	logic rst_b = 1'h0;
	logic cyc = 1'h0, stb = 1'h0, we = 1'h0, ack, take, valid, irq_o;
	logic [7:0] adr = 8'h00, trq = 8'h00, n_got;
	logic [31:0] dat = 32'h0, q, rdat;
	logic [117:0] irq = '0;
	logic [3:0] delay = 4'h0;
	logic [23:0] pc;
	vecsel_pkg::vec_type vo, got;
	logic [7:0] tr [5] = '{8'h01, 8'h80, 8'h00, 8'h02, 8'h00};
	logic [1:0] ir [5] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3};
	logic [6:0] sl [5] = '{7'h00, 7'h07, 7'h08, 7'h01, 7'h08};
	int n_fail = 0, n_tests = 0;
	always #20 clk_sys = ~clk_sys;
	vector_select DUT (.clk_sys(clk_sys), .rst_b(rst_b), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .trap_req(trq),
		.irq_req(irq), .vec_take(take), .vec_valid(valid), .vec_out(vo),
		.start_pc(pc), .irq_o(irq_o));
	cpu_fetch_model core (.clk_sys(clk_sys), .rst_b(rst_b),
		.vec_valid(valid), .vec_out(vo), .delay(delay), .vec_take(take),
		.got(got), .n_got(n_got));
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int t;
		t = 0;
		@(posedge clk_sys);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_sys);
			t++;
		end while (ack !== 1'h1 && t < 20);
		q = rdat;
		if (t >= 20) n_fail++;
		cyc <= 1'h0;
		stb <= 1'h0;
		we <= 1'h0;
	endtask
	// Requests drop once offered so a held level is not issued twice.
	task automatic vec(input logic [7:0] t8, input logic [117:0] i8);
		int t;
		logic [7:0] n0;
		t = 0;
		n0 = n_got;
		@(posedge clk_sys);
		trq <= t8;
		irq <= i8;
		do begin
			@(posedge clk_sys);
			t++;
			if (valid === 1'h1) begin
				trq <= 8'h00;
				irq <= '0;
			end
		end while (n_got === n0 && t < 40);
		if (t >= 40) n_fail++;
	endtask
	function automatic logic [23:0] isr(input int a, input logic [6:0] s);
		return {4'h3, 3'h0, a[0], 8'h00, 1'h0, s};
	endfunction
	task automatic wrap_up;
		$display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge clk_sys);
		rst_b <= 1'h1;
		chk(32'(pc), 32'h0);
		chk(32'(valid), 32'h0);
		for (int a = 0; a < 2; a++) begin
			for (int i = 0; i < 5; i++) begin
				wb(1'h1, `OFS_TBL_INDEX, {24'h0, a[0], sl[i]});
				wb(1'h1, `OFS_TBL_DATA, 32'(isr(a, sl[i])));
			end
		end
		for (int a = 0; a < 2; a++) begin
			wb(1'h1, `OFS_CTRL, a ? 32'h8000 : 32'h0);
			wb(1'h0, `OFS_CTRL, 32'h0);
			chk(q, a ? 32'h8000 : 32'h0);
			for (int i = 0; i < 5; i++) begin
				delay <= 4'(i * 3);
				vec(tr[i], {116'h0, ir[i]});
				chk(32'(got.slot), 32'(sl[i]));
				chk(32'(got.fetch_addr), 32'((a ? 24'h000104 : 24'h000004)
					+ {16'h0, sl[i], 1'h0}));
				chk(32'(got.isr_addr), 32'(isr(a, sl[i])));
				chk({30'h0, got.alt, got.trap},
					{30'h0, a[0], sl[i] < 7'h08});
			end
		end
		chk(32'(got.fetch_addr), 32'h000114);
		wb(1'h0, `OFS_VECTOR, 32'h0);
		chk(q, 32'h108);
		wb(1'h0, `OFS_TBL_INDEX, 32'h0);
		chk(q, 32'h88);
		wb(1'h0, `OFS_TBL_DATA, 32'h0);
		chk(q, 32'(isr(1, 7'h08)));
		chk(32'(irq_o), 32'h0);
		wb(1'h0, `OFS_STATUS, 32'h0);
		chk(q, 32'h3);
		wb(1'h1, `OFS_MASK, 32'h1);
		repeat (2) @(posedge clk_sys);
		chk(32'(irq_o), 32'h1);
		wb(1'h1, `OFS_STATUS, 32'h1);
		wb(1'h0, `OFS_STATUS, 32'h0);
		chk(q, 32'h2);
		repeat (2) @(posedge clk_sys);
		chk(32'(irq_o), 32'h0);
		wb(1'h1, 8'h40, 32'hffffffff);
		wb(1'h0, 8'h40, 32'h0);
		chk(q, 32'h0);
		wb(1'h1, `OFS_CTRL, 32'h8000);
		@(posedge clk_sys);
		trq <= 8'h10;
		rst_b <= 1'h0;
		repeat (3) @(posedge clk_sys);
		chk(32'(valid), 32'h0);
		rst_b <= 1'h1;
		trq <= 8'h00;
		wb(1'h0, `OFS_CTRL, 32'h0);
		chk(q, 32'h0);
		chk(32'(pc), 32'h0);
		chk(32'(valid), 32'h0);
		wrap_up;
	end
	// The tests take some 220 cycles; this limit of 10000 cycles is ample above that.
	initial begin
		#400000;
		n_fail++;
		wrap_up;
	end
endmodule
`default_nettype wire
